// ---- shared/rge_pkg.sv ----
// Constants and carrier types for the regulator enable gating block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package rge_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;

  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_KEYPAD = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  localparam int unsigned CTRL_RXA_EN   = 0;
  localparam int unsigned CTRL_RXB_EN   = 1;
  localparam int unsigned CTRL_RXA_OVR  = 2;
  localparam int unsigned CTRL_RXB_OVR  = 3;
  localparam int unsigned CTRL_BACKLIGHT_DRIVE   = 4;
  localparam int unsigned CTRL_W        = 5;

  localparam int unsigned KEYPAD_COL_LSB = 0;
  localparam int unsigned KEYPAD_COL_MAX = 8;

  localparam int unsigned STAT_MAIN_EN   = 0;
  localparam int unsigned STAT_SLEEP_N   = 1;
  localparam int unsigned STAT_HOLD      = 2;
  localparam int unsigned STAT_RXA_ON    = 3;
  localparam int unsigned STAT_RXB_ON    = 4;
  localparam int unsigned STAT_MAIN_ON   = 5;
  localparam int unsigned STAT_ROW_LSB   = 8;
  localparam int unsigned STAT_ROW_MAX   = 8;
  localparam int unsigned STAT_KEY_DOWN  = 16;

  localparam int unsigned NUM_COLS_DEF = 4;
  localparam int unsigned NUM_ROWS_DEF = 6;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] KEYPAD_RST = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic backlight_on;
    logic rx_b_override;
    logic rx_a_override;
    logic rx_b_enable;
    logic rx_a_enable;
  } rge_ctrl_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } rge_req_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } rge_bus_state_t;

endpackage

// ---- rtl/rge_top.sv ----
// Regulator enable gating, keypad strobe drive and row sense.
// Assumes pins synchronous to clk_sys and a 32-bit Avalon-MM master.
`timescale 1ns/1ns
`default_nettype none

module rge_top #(
  parameter int unsigned NUM_COLS = rge_pkg::NUM_COLS_DEF,
  parameter int unsigned NUM_ROWS = rge_pkg::NUM_ROWS_DEF
) (
  // Clock and reset.
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,

  // Avalon-MM slave.
  input  wire logic [rge_pkg::ADDR_W-1:0]  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [rge_pkg::DATA_W-1:0]  writedata,
  input  wire logic [rge_pkg::BE_W-1:0]    byteenable,
  output logic      [rge_pkg::DATA_W-1:0]  readdata,
  output logic                             waitrequest,

  // Power control pins from the baseband processor.
  input  wire logic                        main_group_enable_in,
  input  wire logic                        sleep_n,
  input  wire logic                        optional_power_hold,

  // Regulator enables.
  output logic                             io_regulator_en,
  output logic                             analog_regulator_en,
  output logic                             coin_cell_regulator_en,
  output logic                             core_regulator_en,
  output logic                             rx_regulator_a_en,
  output logic                             rx_regulator_b_en,
  output logic                             power_keep_on,

  // Open-drain backlight drive.
  output logic                             backlight_drive_o,
  output logic                             backlight_drive_oe,

  // Keypad.
  output logic      [NUM_COLS-1:0]         keypad_column_strobe_o,
  output logic      [NUM_COLS-1:0]         keypad_column_strobe_oe,
  input  wire logic [NUM_ROWS-1:0]         keypad_row_sense_i
);

  localparam bit COLS_OK = NUM_COLS >= 1 &&
                           NUM_COLS <= rge_pkg::KEYPAD_COL_MAX;
  localparam bit ROWS_OK = NUM_ROWS >= 1 &&
                           NUM_ROWS <= rge_pkg::STAT_ROW_MAX;

  // Refuses sizes that the register images cannot hold.
  generate
    if (!COLS_OK) begin : g_bad_cols
      $error("NUM_COLS out of range");
    end
    if (!ROWS_OK) begin : g_bad_rows
      $error("NUM_ROWS out of range");
    end
  endgenerate

  // Decodes a byte offset into a one-hot register select.
  function automatic logic [2:0] sel_of(input logic [rge_pkg::ADDR_W-1:0] a);
    logic [2:0] s;
    s = 3'h0;
    case (a)
      rge_pkg::OFS_CTRL: begin
        s = 3'h1;
      end
      rge_pkg::OFS_KEYPAD: begin
        s = 3'h2;
      end
      rge_pkg::OFS_STATUS: begin
        s = 3'h4;
      end
      default: begin
        s = 3'h0;
      end
    endcase
    return s;
  endfunction

  // Merges write data into a register under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Gates a receive regulator enable with the sleep pin and its override.
  function automatic logic rx_gate(input logic enable,
                                   input logic awake,
                                   input logic override);
    return enable & (awake | override);
  endfunction

  rge_pkg::rge_req_t       req;
  rge_pkg::rge_bus_state_t state_r;
  rge_pkg::rge_bus_state_t state_nxt;
  rge_pkg::rge_ctrl_t      ctrl_r;
  rge_pkg::rge_ctrl_t      ctrl_nxt;
  logic [NUM_COLS-1:0]     cols_r;
  logic [NUM_COLS-1:0]     cols_nxt;
  logic [31:0]             rdata_r;
  logic [31:0]             rdata_nxt;
  logic [31:0]             ctrl_word;
  logic [31:0]             keypad_word;
  logic [31:0]             status_word;
  logic [2:0]              sel;
  logic                    accept;
  logic                    key_down;
  logic                    rx_a_on;
  logic                    rx_b_on;
  logic                    main_on;
  logic [1:0]              rx_enable;
  logic [1:0]              rx_override;
  logic [1:0]              rx_on;

  assign req.read       = read;
  assign req.write      = write;
  assign req.address    = address;
  assign req.writedata  = writedata;
  assign req.byteenable = byteenable;

  assign sel    = sel_of(req.address);
  assign accept = (state_r == rge_pkg::BUS_ACK);

  // Regulator gating.
  assign main_on = main_group_enable_in;
  assign io_regulator_en        = main_on;
  assign analog_regulator_en    = main_on;
  assign coin_cell_regulator_en = main_on;
  assign core_regulator_en      = main_on;

  assign rx_enable   = {ctrl_r.rx_b_enable, ctrl_r.rx_a_enable};
  assign rx_override = {ctrl_r.rx_b_override, ctrl_r.rx_a_override};

  genvar r;
  generate
    for (r = 0; r < 2; r++) begin : g_rx
      assign rx_on[r] = rx_gate(rx_enable[r], sleep_n, rx_override[r]);
    end
  endgenerate
  assign rx_a_on = rx_on[0];
  assign rx_b_on = rx_on[1];
  assign rx_regulator_a_en = rx_a_on;
  assign rx_regulator_b_en = rx_b_on;

  assign power_keep_on = optional_power_hold;

  assign backlight_drive_o  = 1'b0;
  assign backlight_drive_oe = ctrl_r.backlight_on;

  // Column strobes pull low only while their drive bit is set.
  genvar c;
  generate
    for (c = 0; c < NUM_COLS; c++) begin : g_col
      assign keypad_column_strobe_o[c]  = 1'b0;
      assign keypad_column_strobe_oe[c] = cols_r[c];
    end
  endgenerate

  // A low row means a pressed key on a strobed column.
  assign key_down = ~(&keypad_row_sense_i);

  // Register word images.
  always_comb begin
    ctrl_word = rge_pkg::READ_ZERO;
    ctrl_word[rge_pkg::CTRL_RXA_EN]  = ctrl_r.rx_a_enable;
    ctrl_word[rge_pkg::CTRL_RXB_EN]  = ctrl_r.rx_b_enable;
    ctrl_word[rge_pkg::CTRL_RXA_OVR] = ctrl_r.rx_a_override;
    ctrl_word[rge_pkg::CTRL_RXB_OVR] = ctrl_r.rx_b_override;
    ctrl_word[rge_pkg::CTRL_BACKLIGHT_DRIVE]  = ctrl_r.backlight_on;
  end

  always_comb begin
    keypad_word = rge_pkg::READ_ZERO;
    keypad_word[rge_pkg::KEYPAD_COL_LSB +: NUM_COLS] = cols_r;
  end

  always_comb begin
    status_word = rge_pkg::READ_ZERO;
    status_word[rge_pkg::STAT_MAIN_EN] = main_group_enable_in;
    status_word[rge_pkg::STAT_SLEEP_N] = sleep_n;
    status_word[rge_pkg::STAT_HOLD]    = optional_power_hold;
    status_word[rge_pkg::STAT_RXA_ON]  = rx_a_on;
    status_word[rge_pkg::STAT_RXB_ON]  = rx_b_on;
    status_word[rge_pkg::STAT_MAIN_ON] = main_on;
    status_word[rge_pkg::STAT_ROW_LSB +: NUM_ROWS] = keypad_row_sense_i;
    status_word[rge_pkg::STAT_KEY_DOWN] = key_down;
  end

  // Bus handshake: one wait cycle, then completion.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rge_pkg::BUS_IDLE: begin
        if (req.read || req.write) begin
          state_nxt = rge_pkg::BUS_ACK;
        end
      end
      rge_pkg::BUS_ACK: begin
        state_nxt = rge_pkg::BUS_IDLE;
      end
      default: begin
        state_nxt = rge_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= rge_pkg::BUS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign waitrequest = ~accept;

  // Read data is captured while the request waits.
  always_comb begin
    rdata_nxt = rdata_r;
    if (state_r == rge_pkg::BUS_IDLE && req.read) begin
      case (sel)
        3'h1: begin
          rdata_nxt = ctrl_word;
        end
        3'h2: begin
          rdata_nxt = keypad_word;
        end
        3'h4: begin
          rdata_nxt = status_word;
        end
        default: begin
          rdata_nxt = rge_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_r <= rge_pkg::READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign readdata = rdata_r;

  // Writes take effect at the completing edge.
  always_comb begin
    logic [31:0] w;
    w = rge_pkg::READ_ZERO;
    ctrl_nxt = ctrl_r;
    cols_nxt = cols_r;
    if (accept && req.write) begin
      if (sel == 3'h1) begin
        w = merge(ctrl_word, req.writedata, req.byteenable);
        ctrl_nxt.rx_a_enable   = w[rge_pkg::CTRL_RXA_EN];
        ctrl_nxt.rx_b_enable   = w[rge_pkg::CTRL_RXB_EN];
        ctrl_nxt.rx_a_override = w[rge_pkg::CTRL_RXA_OVR];
        ctrl_nxt.rx_b_override = w[rge_pkg::CTRL_RXB_OVR];
        ctrl_nxt.backlight_on  = w[rge_pkg::CTRL_BACKLIGHT_DRIVE];
      end
      if (sel == 3'h2) begin
        w = merge(keypad_word, req.writedata, req.byteenable);
        cols_nxt = w[rge_pkg::KEYPAD_COL_LSB +: NUM_COLS];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r  <= rge_pkg::rge_ctrl_t'(rge_pkg::CTRL_RST[rge_pkg::CTRL_W-1:0]);
      cols_r  <= rge_pkg::KEYPAD_RST[NUM_COLS-1:0];
    end else begin
      ctrl_r  <= ctrl_nxt;
      cols_r  <= cols_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- tb/rge_top_checker.sv ----
// Checker for the regulator gating block, watching its top ports.
// Bound to rge_top from the testbench top file.
`timescale 1ns/1ns
`default_nettype none
module rge_top_checker #(
  parameter int unsigned NUM_COLS = 4
) (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                read,
  input wire logic                write,
  input wire logic                waitrequest,
  input wire logic                main_group_enable_in,
  input wire logic                sleep_n,
  input wire logic                optional_power_hold,
  input wire logic                io_regulator_en,
  input wire logic                analog_regulator_en,
  input wire logic                coin_cell_regulator_en,
  input wire logic                core_regulator_en,
  input wire logic                rx_regulator_a_en,
  input wire logic                rx_regulator_b_en,
  input wire logic                power_keep_on,
  input wire logic [NUM_COLS-1:0] keypad_column_strobe_o,
  input wire logic [NUM_COLS-1:0] keypad_column_strobe_oe
);
  logic wr_w;
  assign wr_w = write && !waitrequest;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence ack_once;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence sleep_quiet;
    $stable(sleep_n) && !$past(wr_w);
  endsequence
  main_group_on_a: assert property (
    {io_regulator_en, analog_regulator_en, coin_cell_regulator_en,
     core_regulator_en} == {4{main_group_enable_in}})
    else $error("Main group enables differ from the pin.");
  rx_rise_a: assert property (
    $rose(rx_regulator_a_en) || $rose(rx_regulator_b_en) |->
      sleep_n || $past(wr_w))
    else $error("Receive regulator rose while sleeping.");
  rx_stable_a: assert property (
    sleep_quiet |-> $stable(rx_regulator_a_en) && $stable(rx_regulator_b_en))
    else $error("Receive enable moved without a cause.");
  hold_follow_a: assert property (
    power_keep_on == optional_power_hold)
    else $error("Power hold output differs from the pin.");
  col_low_a: assert property (
    keypad_column_strobe_o == '0)
    else $error("Column strobe drives high.");
  col_oe_a: assert property (
    $changed(keypad_column_strobe_oe) |-> $past(wr_w))
    else $error("Column drive moved without a write.");
  one_wait_a: assert property ($rose(read || write) |=> ack_once)
    else $error("Bus answer not after one wait cycle.");
  idle_wait_a: assert property (
    !read && !write && !$past(read || write) |-> waitrequest)
    else $error("Waitrequest low while idle.");
endmodule
`default_nettype wire

// ---- tb/rge_keypad_model.sv ----
// Keypad matrix with row pull-ups, one key pressed at a time.
// Key index 15 means no key; columns pull low only while driven.
`timescale 1ns/1ns
`default_nettype none
module rge_keypad_model (
  input  wire logic [3:0] col_oe,
  input  wire logic [3:0] key_row,
  input  wire logic [3:0] key_col,
  output logic      [5:0] rows
);
  always_comb begin
    rows = 6'h3F;
    if (key_row < 4'h6 && key_col < 4'h4 && col_oe[key_col[1:0]])
      rows[key_row[2:0]] = 1'b0;
  end
endmodule
`default_nettype wire

// ---- tb/test_rge_top.sv ----
// Testbench for the regulator gating block with a keypad model.
// Drives pins and the Avalon-MM bus at clk_sys rising edges.
`timescale 1ns/1ns
`default_nettype none
module test_rge_top;
  logic        clk_sys, rst_n, read, write, waitrequest, bl_o, bl_oe;
  logic        main_group_enable_in, sleep_n, optional_power_hold;
  logic        io_en, an_en, cc_en, co_en, rxa, rxb, power_keep_on;
  logic [3:0]  address, col_o, col_oe, key_row, key_col;
  logic [31:0] writedata, readdata, rd;
  logic [5:0]  rows;
  int          num_errors, checked;
  rge_top i_rge_top (.clk_sys, .rst_n, .address, .read, .write, .writedata,
    .byteenable(4'hF), .readdata, .waitrequest, .main_group_enable_in,
    .sleep_n, .optional_power_hold, .io_regulator_en(io_en),
    .analog_regulator_en(an_en), .coin_cell_regulator_en(cc_en),
    .core_regulator_en(co_en), .rx_regulator_a_en(rxa),
    .rx_regulator_b_en(rxb), .power_keep_on, .backlight_drive_o(bl_o),
    .backlight_drive_oe(bl_oe), .keypad_column_strobe_o(col_o),
    .keypad_column_strobe_oe(col_oe), .keypad_row_sense_i(rows));
  rge_keypad_model i_rge_keypad_model (.col_oe, .key_row, .key_col, .rows);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      chk("timeout", 32'h0000_0000, 32'h0000_0001);
      final_report();
    end
  endtask
  task automatic t_regs();
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", 32'h0000_0000, rd);
    bus(1'b0, 4'h4, 32'h0);
    chk("keypad reset", 32'h0000_0000, rd);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b1, 4'h8, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0000_0000, rd);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl kept", 32'h0000_0000, rd);
    $display("test regs done");
  endtask
  task automatic t_main();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      main_group_enable_in <= i[0];
      optional_power_hold <= i[1];
      @(negedge clk_sys);
      chk("main", {28'h0, {4{i[0]}}},
          {28'h0, io_en, an_en, cc_en, co_en});
      chk("hold", {31'h0, i[1]}, {31'h0, power_keep_on});
    end
    $display("test main done");
  endtask
  task automatic t_rx();
    logic [4:0] c;
    logic [1:0] e;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 32; k++) begin
        c = k[4:0];
        e = {c[1] & (s[0] | c[3]), c[0] & (s[0] | c[2])};
        @(posedge clk_sys);
        sleep_n <= s[0];
        main_group_enable_in <= 1'b1;
        optional_power_hold <= 1'b1;
        bus(1'b1, 4'h0, {27'h0, c});
        @(negedge clk_sys);
        chk("rx", {30'h0, e},
            {30'h0, rxb, rxa});
        chk("backlight_drive", {30'h0, c[4], 1'b0}, {30'h0, bl_oe, bl_o});
        bus(1'b0, 4'h8, 32'h0);
        chk("status", {26'h0, 1'b1, e, 1'b1, s[0], 1'b1},
            rd & 32'h0000_003F);
      end
    end
    $display("test rx done");
  endtask
  task automatic t_keys();
    logic [3:0] r;
    for (int c = 0; c < 4; c++) begin
      r = 4'((c * 5) % 6);
      bus(1'b1, 4'h4, 32'h1 << c);
      key_row <= r;
      key_col <= 4'(c);
      @(negedge clk_sys);
      chk("cols", {24'h0, 4'h1 << c, 4'h0},
          {24'h0, col_oe, col_o});
      bus(1'b0, 4'h8, 32'h0);
      chk("row low", {15'h0, 1'b1, 2'h0, 6'h3F & ~(6'h1 << r), 8'h0},
          rd & 32'h0001_3F00);
      key_col <= 4'((c + 1) % 4);
      bus(1'b0, 4'h8, 32'h0);
      chk("row idle", 32'h0000_3F00,
          rd & 32'h0001_3F00);
    end
    $display("test keys done");
  endtask
  initial begin
    rst_n = 1'b0;
    {read, write, address, writedata} = '0;
    {main_group_enable_in, optional_power_hold, sleep_n} = 3'h1;
    key_row = 4'hF;
    key_col = 4'hF;
    num_errors = 0;
    checked = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_main();
    t_rx();
    t_keys();
    final_report();
  end
endmodule
bind rge_top rge_top_checker #(.NUM_COLS(NUM_COLS)) i_rge_top_checker (
  .clk_sys, .rst_n, .read, .write, .waitrequest, .main_group_enable_in,
  .sleep_n, .optional_power_hold, .io_regulator_en, .analog_regulator_en,
  .coin_cell_regulator_en, .core_regulator_en, .rx_regulator_a_en,
  .rx_regulator_b_en, .power_keep_on, .keypad_column_strobe_o,
  .keypad_column_strobe_oe);
`default_nettype wire
